/* rtl/apsr_pkg.sv */
// constants and carrier types for the audio port signal routing block
package apsr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] IF_DIR_OFF      = 8'h1b;
  localparam logic [7:0] SEC_PIN_SEL_OFF = 8'h1f;
  localparam logic [7:0] CLK_SRC_SEL_OFF = 8'h20;
  localparam logic [7:0] OUT_ROUTE_OFF   = 8'h21;
  localparam logic [7:0] MISC_CFG_OFF    = 8'h22;
  localparam logic [7:0] RSVD_35_OFF     = 8'h23;
  localparam logic [7:0] REC_STATUS_OFF  = 8'h24;

  // ==========================================================
  // writable masks and reset values
  localparam logic [7:0] IF_DIR_MASK      = 8'h0c;
  localparam logic [7:0] SEC_PIN_SEL_MASK = 8'h7f;
  localparam logic [7:0] CLK_SRC_SEL_MASK = 8'h0f;
  localparam logic [7:0] OUT_ROUTE_MASK   = 8'hff;
  localparam logic [7:0] MISC_CFG_MASK    = 8'h20;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // ==========================================================
  // field positions
  localparam int DIR_BCLK_BIT   = 3;
  localparam int DIR_WCLK_BIT   = 2;
  localparam int SEC_BCLK_LSB   = 5;
  localparam int SEC_WCLK_LSB   = 3;
  localparam int REC_WCLK_LSB   = 1;
  localparam int SEC_DIN_BIT    = 0;
  localparam int USE_SBCLK_BIT  = 3;
  localparam int USE_SWCLK_BIT  = 2;
  localparam int USE_RWCLK_BIT  = 1;
  localparam int USE_SDIN_BIT   = 0;
  localparam int BCLK_OUT_BIT   = 7;
  localparam int SBCLK_OUT_BIT  = 6;
  localparam int WCLK_OUT_LSB   = 4;
  localparam int SWCLK_OUT_LSB  = 2;
  localparam int DOUT_LOOP_BIT  = 1;
  localparam int SDOUT_PORT_BIT = 0;
  localparam int GEN_CALL_BIT   = 5;
  localparam int ST_LEFT_LSB    = 4;
  localparam int ST_RIGHT_LSB   = 0;
  localparam int ST_EQUAL_OFS   = 3;
  localparam int ST_POWER_OFS   = 2;
  localparam int ST_SAT_OFS     = 1;

  // ==========================================================
  // multi-function pin choices
  typedef enum logic [1:0] {
    APSR_PIN_GPIO = 2'b00,
    APSR_PIN_SCLK = 2'b01,
    APSR_PIN_MISO = 2'b10,
    APSR_PIN_DOUT = 2'b11
  } apsr_pin_sel_t;

  // primary word clock output choices
  typedef enum logic [1:0] {
    APSR_WO_PLAY = 2'b00,
    APSR_WO_REC  = 2'b01,
    APSR_WO_SEC  = 2'b10,
    APSR_WO_RSVD = 2'b11
  } apsr_wclk_out_t;

  // secondary word clock output choices
  typedef enum logic [1:0] {
    APSR_SO_PIN  = 2'b00,
    APSR_SO_PLAY = 2'b01,
    APSR_SO_REC  = 2'b10,
    APSR_SO_RSVD = 2'b11
  } apsr_swclk_out_t;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic gpio;
    logic sclk;
    logic miso;
    logic dout;
    logic bclk;
    logic wclk;
    logic din;
  } apsr_pins_t;

  // clocks and data generated by the serial port core
  typedef struct packed {
    logic bclk;
    logic play_fs;
    logic rec_fs;
    logic dout;
  } apsr_gen_t;

  // per record channel status from the analog side
  typedef struct packed {
    logic gain_equal;
    logic powered;
    logic gain_max;
  } apsr_rec_t;

endpackage

/* rtl/apsr_top.sv */
// audio port pin multiplexing, clock/data routing and record status flags
// Function
// - two-bit field picks secondary bit clock pin: gpio, sclk, miso, dout.
// - two-bit field picks secondary word clock pin with the same encoding.
// - two-bit field picks record word clock pin; value 11 never programmed.
// - one bit picks secondary data input pin: gpio or sclk.
// - bit picks primary or secondary bit clock for port and clocking.
// - bit picks primary or secondary word clock for the port.
// - bit picks playback word clock or secondary record word clock.
// - bit picks primary data-in pin or secondary data input.
// - driven bit clock pin carries generated clock or secondary input.
// - secondary bit clock output carries bit clock pin or generated clock.
// - primary word clock output: playback rate, record rate, secondary; 11 unused.
// - secondary word clock output: pin input, playback, record; 11 unused.
// - data-out pin carries port data or loops secondary data input.
// - secondary data output loops data-in pin or carries port data.
// - general call accepted only while its enable bit is one.
// - per channel flag shows applied gain equals programmed gain.
// - per channel flag shows converter power state.
// - per channel sticky saturation flag clears when status is read.
// - direction bits decide whether bit and word clock pins are driven.
`timescale 1ns/10ps
module apsr_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic               clock,
  input  wire logic               arst_n,
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [7:0]         reg_rdata,
  input  wire apsr_pkg::apsr_pins_t pin_in,
  input  wire apsr_pkg::apsr_gen_t  gen_in,
  input  wire apsr_pkg::apsr_rec_t  rec_left,
  input  wire apsr_pkg::apsr_rec_t  rec_right,
  output logic                    bclk_out,
  output logic                    bclk_oe_n,
  output logic                    wclk_out,
  output logic                    wclk_oe_n,
  output logic                    dout_out,
  output logic                    dout_oe_n,
  output logic                    sec_bclk_out,
  output logic                    sec_wclk_out,
  output logic                    sec_dout_out,
  output logic                    port_bclk,
  output logic                    port_bclk_rise,
  output logic                    port_wclk,
  output logic                    port_rec_wclk,
  output logic                    port_din,
  output logic                    gen_call_en
);

  // ==========================================================
  // parameter check
  if (ADDR_W < 6) begin : g_bad_addr
    $error("apsr_top: ADDR_W must be at least 6");
  end

  // ==========================================================
  // pin synchronisers
  apsr_pkg::apsr_pins_t sync1_q;
  apsr_pkg::apsr_pins_t pins_q;

  for (genvar i = 0; i < $bits(apsr_pkg::apsr_pins_t); i++) begin : g_sync
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        sync1_q[i] <= 1'b0;
        pins_q[i]  <= 1'b0;
      end else begin
        sync1_q[i] <= pin_in[i];
        pins_q[i]  <= sync1_q[i];
      end
    end
  end

  // ==========================================================
  // register file
  logic [7:0] dir_q;
  logic [7:0] pin_sel_q;
  logic [7:0] src_sel_q;
  logic [7:0] route_q;
  logic [7:0] misc_q;
  logic       hit_dir;
  logic       hit_pin;
  logic       hit_src;
  logic       hit_route;
  logic       hit_misc;
  logic       hit_status;

  assign hit_dir    = (reg_addr == ADDR_W'(apsr_pkg::IF_DIR_OFF));
  assign hit_pin    = (reg_addr == ADDR_W'(apsr_pkg::SEC_PIN_SEL_OFF));
  assign hit_src    = (reg_addr == ADDR_W'(apsr_pkg::CLK_SRC_SEL_OFF));
  assign hit_route  = (reg_addr == ADDR_W'(apsr_pkg::OUT_ROUTE_OFF));
  assign hit_misc   = (reg_addr == ADDR_W'(apsr_pkg::MISC_CFG_OFF));
  assign hit_status = (reg_addr == ADDR_W'(apsr_pkg::REC_STATUS_OFF));

  // reserved bits stay at reset value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dir_q     <= apsr_pkg::REG_RESET;
      pin_sel_q <= apsr_pkg::REG_RESET;
      src_sel_q <= apsr_pkg::REG_RESET;
      route_q   <= apsr_pkg::REG_RESET;
      misc_q    <= apsr_pkg::REG_RESET;
    end else if (reg_wr) begin
      if (hit_dir) begin
        dir_q <= reg_wdata & apsr_pkg::IF_DIR_MASK;
      end else if (hit_pin) begin
        pin_sel_q <= reg_wdata & apsr_pkg::SEC_PIN_SEL_MASK;
      end else if (hit_src) begin
        src_sel_q <= reg_wdata & apsr_pkg::CLK_SRC_SEL_MASK;
      end else if (hit_route) begin
        route_q <= reg_wdata & apsr_pkg::OUT_ROUTE_MASK;
      end else if (hit_misc) begin
        misc_q <= reg_wdata & apsr_pkg::MISC_CFG_MASK;
      end
    end
  end

  // ==========================================================
  // record status flags
  logic [1:0] sat_q;
  logic [1:0] sat_set;
  logic [1:0] eq_q;
  logic [1:0] pwr_q;
  logic       status_rd;

  assign sat_set   = {rec_left.gain_max, rec_right.gain_max};
  assign status_rd = reg_rd && hit_status;

  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        sat_q[c] <= 1'b0;
      end else if (sat_set[c]) begin
        sat_q[c] <= 1'b1;
      end else if (status_rd) begin
        sat_q[c] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      eq_q  <= 2'b00;
      pwr_q <= 2'b00;
    end else begin
      eq_q  <= {rec_left.gain_equal, rec_right.gain_equal};
      pwr_q <= {rec_left.powered, rec_right.powered};
    end
  end

  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[apsr_pkg::ST_LEFT_LSB + apsr_pkg::ST_EQUAL_OFS]  = eq_q[1];
    status_word[apsr_pkg::ST_LEFT_LSB + apsr_pkg::ST_POWER_OFS]  = pwr_q[1];
    status_word[apsr_pkg::ST_LEFT_LSB + apsr_pkg::ST_SAT_OFS]    = sat_q[1];
    status_word[apsr_pkg::ST_RIGHT_LSB + apsr_pkg::ST_EQUAL_OFS] = eq_q[0];
    status_word[apsr_pkg::ST_RIGHT_LSB + apsr_pkg::ST_POWER_OFS] = pwr_q[0];
    status_word[apsr_pkg::ST_RIGHT_LSB + apsr_pkg::ST_SAT_OFS]   = sat_q[0];
  end

  // ==========================================================
  // read port: data one cycle after the strobe, zero elsewhere
  logic [7:0] rdata_d;
  always_comb begin
    if (hit_dir) begin
      rdata_d = dir_q;
    end else if (hit_pin) begin
      rdata_d = pin_sel_q;
    end else if (hit_src) begin
      rdata_d = src_sel_q;
    end else if (hit_route) begin
      rdata_d = route_q;
    end else if (hit_misc) begin
      rdata_d = misc_q;
    end else if (hit_status) begin
      rdata_d = status_word;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // field decode
  apsr_pkg::apsr_pin_sel_t   sbclk_pin;
  apsr_pkg::apsr_pin_sel_t   swclk_pin;
  apsr_pkg::apsr_pin_sel_t   rwclk_pin;
  apsr_pkg::apsr_wclk_out_t  wclk_sel;
  apsr_pkg::apsr_swclk_out_t swclk_sel;

  assign sbclk_pin = apsr_pkg::apsr_pin_sel_t'(pin_sel_q[apsr_pkg::SEC_BCLK_LSB +: 2]);
  assign swclk_pin = apsr_pkg::apsr_pin_sel_t'(pin_sel_q[apsr_pkg::SEC_WCLK_LSB +: 2]);
  assign rwclk_pin = apsr_pkg::apsr_pin_sel_t'(pin_sel_q[apsr_pkg::REC_WCLK_LSB +: 2]);
  assign wclk_sel  = apsr_pkg::apsr_wclk_out_t'(route_q[apsr_pkg::WCLK_OUT_LSB +: 2]);
  assign swclk_sel = apsr_pkg::apsr_swclk_out_t'(route_q[apsr_pkg::SWCLK_OUT_LSB +: 2]);

  function automatic logic pick_pin(input apsr_pkg::apsr_pin_sel_t sel, input apsr_pkg::apsr_pins_t p);
    logic r;
    case (sel)
      apsr_pkg::APSR_PIN_GPIO: r = p.gpio;
      apsr_pkg::APSR_PIN_SCLK: r = p.sclk;
      apsr_pkg::APSR_PIN_MISO: r = p.miso;
      default:                 r = p.dout;
    endcase
    return r;
  endfunction

  // ==========================================================
  // secondary inputs from multi-function pins
  logic sec_bclk;
  logic sec_wclk;
  logic sec_rwclk;
  logic sec_din;

  assign sec_bclk = pick_pin(sbclk_pin, pins_q);
  assign sec_wclk = pick_pin(swclk_pin, pins_q);
  // record word clock pin, dout choice unused
  assign sec_rwclk = (rwclk_pin == apsr_pkg::APSR_PIN_DOUT) ? 1'b0 : pick_pin(rwclk_pin, pins_q);
  assign sec_din = pin_sel_q[apsr_pkg::SEC_DIN_BIT] ? pins_q.sclk : pins_q.gpio;

  // ==========================================================
  // port-side clock and data selection
  logic bclk_sel_d;
  logic wclk_sel_d;
  logic bclk_prev_q;

  // bit clock source for port and clocking
  assign bclk_sel_d = src_sel_q[apsr_pkg::USE_SBCLK_BIT] ? sec_bclk : pins_q.bclk;
  assign wclk_sel_d = src_sel_q[apsr_pkg::USE_SWCLK_BIT] ? sec_wclk : pins_q.wclk;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_bclk      <= 1'b0;
      port_wclk      <= 1'b0;
      port_rec_wclk  <= 1'b0;
      port_din       <= 1'b0;
      bclk_prev_q    <= 1'b0;
      port_bclk_rise <= 1'b0;
    end else begin
      port_bclk      <= bclk_sel_d;
      port_wclk      <= wclk_sel_d;
      // record word clock follows playback or secondary
      port_rec_wclk  <= src_sel_q[apsr_pkg::USE_RWCLK_BIT] ? sec_rwclk : wclk_sel_d;
      // data in from primary pin or secondary
      port_din       <= src_sel_q[apsr_pkg::USE_SDIN_BIT] ? sec_din : pins_q.din;
      bclk_prev_q    <= bclk_sel_d;
      port_bclk_rise <= bclk_sel_d & ~bclk_prev_q;
    end
  end

  // ==========================================================
  // output pin routing
  logic dout_is_input;
  assign dout_is_input = (src_sel_q[apsr_pkg::USE_SBCLK_BIT] && sbclk_pin == apsr_pkg::APSR_PIN_DOUT)
                      || (src_sel_q[apsr_pkg::USE_SWCLK_BIT] && swclk_pin == apsr_pkg::APSR_PIN_DOUT);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bclk_out     <= 1'b0;
      bclk_oe_n    <= 1'b1;
      wclk_out     <= 1'b0;
      wclk_oe_n    <= 1'b1;
      dout_out     <= 1'b0;
      dout_oe_n    <= 1'b1;
      sec_bclk_out <= 1'b0;
      sec_wclk_out <= 1'b0;
      sec_dout_out <= 1'b0;
      gen_call_en  <= 1'b0;
    end else begin
      // bit and word clock pins driven only when their direction bit set
      bclk_oe_n <= ~dir_q[apsr_pkg::DIR_BCLK_BIT];
      wclk_oe_n <= ~dir_q[apsr_pkg::DIR_WCLK_BIT];
      bclk_out <= route_q[apsr_pkg::BCLK_OUT_BIT] ? sec_bclk : gen_in.bclk;
      sec_bclk_out <= route_q[apsr_pkg::SBCLK_OUT_BIT] ? gen_in.bclk : pins_q.bclk;
      case (wclk_sel)
        apsr_pkg::APSR_WO_PLAY: wclk_out <= gen_in.play_fs;
        apsr_pkg::APSR_WO_REC:  wclk_out <= gen_in.rec_fs;
        apsr_pkg::APSR_WO_SEC:  wclk_out <= sec_wclk;
        default:                wclk_out <= 1'b0;
      endcase
      case (swclk_sel)
        apsr_pkg::APSR_SO_PIN:  sec_wclk_out <= pins_q.wclk;
        apsr_pkg::APSR_SO_PLAY: sec_wclk_out <= gen_in.play_fs;
        apsr_pkg::APSR_SO_REC:  sec_wclk_out <= gen_in.rec_fs;
        default:                sec_wclk_out <= 1'b0;
      endcase
      dout_out  <= route_q[apsr_pkg::DOUT_LOOP_BIT] ? sec_din : gen_in.dout;
      dout_oe_n <= dout_is_input;
      // secondary data output source or loopback
      sec_dout_out <= route_q[apsr_pkg::SDOUT_PORT_BIT] ? gen_in.dout : pins_q.din;
      gen_call_en <= misc_q[apsr_pkg::GEN_CALL_BIT];
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_bclk_dir_drive: assert property (
    (reg_wr && hit_dir) |=> ##1 (bclk_oe_n == ~$past(reg_wdata[apsr_pkg::DIR_BCLK_BIT], 2)))
    else $error("bit clock pin direction does not follow its write");

  a_rd_data_time: assert property (
    (reg_wr && hit_route) ##1 !reg_wr ##1 (reg_rd && hit_route) |=> (reg_rdata == $past(reg_wdata, 3)))
    else $error("route register readback differs from write");

  a_rsvd_read_zero: assert property (
    (reg_rd && !(hit_dir || hit_pin || hit_src || hit_route || hit_misc || hit_status)) |=> (reg_rdata == 8'h00))
    else $error("unmapped or reserved read not zero");

  a_sat_sticky_hold: assert property (
    (sat_q[1] && !status_rd) |=> sat_q[1])
    else $error("saturation flag dropped without a read");

  a_sat_read_clear: assert property (
    (status_rd && !sat_set[1] && !sat_set[0]) |=> (sat_q == 2'b00))
    else $error("saturation flags not cleared by read");

  a_sat_set_wins: assert property (
    (status_rd && sat_set[0]) |=> sat_q[0])
    else $error("saturation event lost on read");

  a_bclk_gen_route: assert property (
    (!route_q[apsr_pkg::BCLK_OUT_BIT]) |=> (bclk_out == $past(gen_in.bclk)))
    else $error("bit clock pin not carrying generated clock");

  a_wclk_rec_route: assert property (
    (wclk_sel == apsr_pkg::APSR_WO_REC) |=> (wclk_out == $past(gen_in.rec_fs)))
    else $error("word clock pin not carrying record rate");

  a_din_loop_route: assert property (
    (!route_q[apsr_pkg::SDOUT_PORT_BIT]) |=> (sec_dout_out == $past(pins_q.din)))
    else $error("secondary data output not looping data-in");

  a_port_bclk_src: assert property (
    (src_sel_q[apsr_pkg::USE_SBCLK_BIT] && sbclk_pin == apsr_pkg::APSR_PIN_MISO) |=> (port_bclk == $past(pins_q.miso)))
    else $error("port bit clock not taken from miso");

  a_gen_call_en: assert property (
    (reg_wr && hit_misc) |=> ##1 (gen_call_en == $past(reg_wdata[apsr_pkg::GEN_CALL_BIT], 2)))
    else $error("general call enable does not follow write");

  c_sat_then_read: cover property (sat_q[1] ##1 status_rd);
  c_dout_loopback: cover property (route_q[apsr_pkg::DOUT_LOOP_BIT] && !dout_oe_n);
  c_sec_bclk_use: cover property (src_sel_q[apsr_pkg::USE_SBCLK_BIT] && port_bclk_rise);

endmodule

/* bench/apsr_host_model.sv */
// host audio processor model that drives the serial port pins
`timescale 1ns/10ps
module apsr_host_model (
  input  wire logic            run,
  input  wire logic            ck_on_sclk,
  input  wire logic [6:0]      level,
  output apsr_pkg::apsr_pins_t pins
);
  logic       lclk  = 1'b0;
  logic [4:0] nfall = 5'h00;
  logic [7:0] pat   = 8'h5a;

  // ==========================================================
  // link clock, 400 ns period, stands low outside frames
  always begin
    if (run) begin
      #200;
      lclk = 1'b1;
      #200;
      lclk = 1'b0;
      nfall = nfall + 5'h01;
      pat = {pat[6:0], pat[7] ^ pat[5] ^ pat[4] ^ pat[3]};
    end else begin
      #13;
    end
  end

  // ==========================================================
  // static levels between frames, word clock and data inside them
  always_comb begin
    pins = apsr_pkg::apsr_pins_t'(level);
    if (run) begin
      if (ck_on_sclk) begin
        pins.sclk = lclk;
      end else begin
        pins.bclk = lclk;
      end
      pins.wclk = nfall[4];
      pins.din  = pat[0];
    end
  end
endmodule

/* bench/tb_top.sv */
// self-checking bench for the audio port signal routing block
`timescale 1ns/10ps
module tb_top;
  logic                 clock, arst_n, reg_wr, reg_rd, run, ck_on_sclk;
  logic [7:0]           reg_addr, reg_wdata, reg_rdata;
  logic [6:0]           level;
  apsr_pkg::apsr_pins_t pin_in;
  apsr_pkg::apsr_gen_t  gen_in;
  apsr_pkg::apsr_rec_t  rec_left, rec_right;
  logic bclk_out, bclk_oe_n, wclk_out, wclk_oe_n, dout_out, dout_oe_n, sec_bclk_out, sec_wclk_out;
  logic sec_dout_out, port_bclk, port_bclk_rise, port_wclk, port_rec_wclk, port_din, gen_call_en;
  logic [7:0]           rf [0:255];
  logic                 sat_l, sat_r;
  logic [31:0]          r;
  int                   n_errors, n_tests, cnt_pin, cnt_rise, cyc;
  logic [7:0] offs [8] = '{apsr_pkg::IF_DIR_OFF, apsr_pkg::SEC_PIN_SEL_OFF, apsr_pkg::CLK_SRC_SEL_OFF,
    apsr_pkg::OUT_ROUTE_OFF, apsr_pkg::MISC_CFG_OFF, apsr_pkg::RSVD_35_OFF, apsr_pkg::REC_STATUS_OFF, 8'h30};

  apsr_top apsr_top_inst (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .gen_in(gen_in),
    .rec_left(rec_left), .rec_right(rec_right), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n),
    .wclk_out(wclk_out), .wclk_oe_n(wclk_oe_n), .dout_out(dout_out), .dout_oe_n(dout_oe_n),
    .sec_bclk_out(sec_bclk_out), .sec_wclk_out(sec_wclk_out), .sec_dout_out(sec_dout_out),
    .port_bclk(port_bclk), .port_bclk_rise(port_bclk_rise), .port_wclk(port_wclk),
    .port_rec_wclk(port_rec_wclk), .port_din(port_din), .gen_call_en(gen_call_en));

  apsr_host_model apsr_host_model_inst (.run(run), .ck_on_sclk(ck_on_sclk), .level(level), .pins(pin_in));

  // ==========================================================
  // helpers and reference model
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      apsr_pkg::IF_DIR_OFF:      return apsr_pkg::IF_DIR_MASK;
      apsr_pkg::SEC_PIN_SEL_OFF: return apsr_pkg::SEC_PIN_SEL_MASK;
      apsr_pkg::CLK_SRC_SEL_OFF: return apsr_pkg::CLK_SRC_SEL_MASK;
      apsr_pkg::OUT_ROUTE_OFF:   return apsr_pkg::OUT_ROUTE_MASK;
      apsr_pkg::MISC_CFG_OFF:    return apsr_pkg::MISC_CFG_MASK;
      default:                   return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rd_exp(input logic [7:0] a);
    if (a == apsr_pkg::REC_STATUS_OFF) begin
      return {rec_left.gain_equal, rec_left.powered, sat_l, 1'b0,
              rec_right.gain_equal, rec_right.powered, sat_r, 1'b0};
    end
    return rf[a];
  endfunction

  function automatic logic [12:0] route_exp();
    logic [3:0] pv, wv, sv;
    logic       secb, secw, recw, sdin, pw;
    logic [7:0] sp, cs, orr;
    sp   = rf[8'h1f];
    cs   = rf[8'h20];
    orr  = rf[8'h21];
    pv   = {pin_in.gpio, pin_in.sclk, pin_in.miso, pin_in.dout};
    secb = pv[~sp[6:5]];
    secw = pv[~sp[4:3]];
    recw = (sp[2:1] == 2'b11) ? 1'b0 : pv[~sp[2:1]];
    sdin = sp[0] ? pin_in.sclk : pin_in.gpio;
    pw   = cs[2] ? secw : pin_in.wclk;
    wv   = {1'b0, secw, gen_in.rec_fs, gen_in.play_fs};
    sv   = {1'b0, gen_in.rec_fs, gen_in.play_fs, pin_in.wclk};
    return {orr[7] ? secb : gen_in.bclk, ~rf[8'h1b][3], wv[orr[5:4]], ~rf[8'h1b][2],
            orr[1] ? sdin : gen_in.dout, orr[6] ? gen_in.bclk : pin_in.bclk, sv[orr[3:2]],
            orr[0] ? gen_in.dout : pin_in.din, cs[3] ? secb : pin_in.bclk, pw,
            cs[1] ? recw : pw, cs[0] ? sdin : pin_in.din, rf[8'h22][5]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // register bus master
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    rf[a] = d & wmask(a);
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = rd_exp(a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check({8'h00, reg_rdata}, {8'h00, e});
    if (a == apsr_pkg::REC_STATUS_OFF) begin
      sat_l = 1'b0;
      sat_r = 1'b0;
    end
  endtask

  task automatic route_chk();
    repeat (5) @(posedge clock);
    @(negedge clock);
    check({3'b000, bclk_out, bclk_oe_n, wclk_out, wclk_oe_n, dout_out, sec_bclk_out, sec_wclk_out,
           sec_dout_out, port_bclk, port_wclk, port_rec_wclk, port_din, gen_call_en},
          {3'b000, route_exp()});
    check({15'h0000, dout_oe_n}, {15'h0000, (rf[8'h20][3] && rf[8'h1f][6:5] == 2'b11)
          || (rf[8'h20][2] && rf[8'h1f][4:3] == 2'b11)});
  endtask

  task automatic frame(input logic on_sclk);
    cnt_pin  = 0;
    cnt_rise = 0;
    ck_on_sclk <= on_sclk;
    run        <= 1'b1;
    #16000;
    run <= 1'b0;
    repeat (20) @(posedge clock);
    check(16'(cnt_rise), 16'(cnt_pin));
    check({15'h0000, cnt_pin >= 30}, 16'h0001);
  endtask

  always @(posedge pin_in.bclk) if (!ck_on_sclk) cnt_pin++;
  always @(posedge pin_in.sclk) if (ck_on_sclk) cnt_pin++;
  always @(posedge clock) if (port_bclk_rise === 1'b1) cnt_rise++;

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clock);
      cyc++;
      if (cyc == 6000) begin
        n_errors++;
        give_verdict();
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {arst_n, reg_wr, reg_rd, run, ck_on_sclk, sat_l, sat_r} = '0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    level     = 7'h00;
    gen_in    = '0;
    rec_left  = '0;
    rec_right = '0;
    r         = 32'h0000_1365;
    n_errors  = 0;
    n_tests   = 0;
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    route_chk();
    foreach (offs[i]) rd_chk(offs[i]);
    // reserved bits written as reset values, no code 11 in record pin or word clock output selectors
    foreach (offs[i]) wr(offs[i], wmask(offs[i]) & 8'hdb);
    foreach (offs[i]) rd_chk(offs[i]);
    for (int i = 0; i < 48; i++) begin
      r = lfsr(lfsr(lfsr(r)));
      // record pin and word clock output selectors never take code 11
      wr(8'h1b, r[7:0] & apsr_pkg::IF_DIR_MASK);
      wr(8'h1f, {1'b0, r[14:11], r[10] & ~r[9], r[9:8]});
      wr(8'h20, r[23:16] & apsr_pkg::CLK_SRC_SEL_MASK);
      wr(8'h21, {r[31:30], r[29] & ~r[28], r[28], r[27] & ~r[26], r[26:24]});
      rd_chk(8'h21);
      wr(8'h22, r[12:5] & apsr_pkg::MISC_CFG_MASK);
      level  <= r[22:16];
      gen_in <= r[7:4];
      route_chk();
    end
    for (int ch = 0; ch < 2; ch++) begin
      r = lfsr(lfsr(r));
      @(posedge clock);
      rec_left  <= {r[0], r[1], ch == 0};
      rec_right <= {r[2], r[3], ch == 1};
      @(posedge clock);
      rec_left.gain_max  <= 1'b0;
      rec_right.gain_max <= 1'b0;
      sat_l = sat_l | (ch == 0);
      sat_r = sat_r | (ch == 1);
      repeat (2) @(posedge clock);
      rd_chk(apsr_pkg::REC_STATUS_OFF);
      rd_chk(apsr_pkg::REC_STATUS_OFF);
    end
    // event in the clearing read cycle survives
    fork
      rd_chk(apsr_pkg::REC_STATUS_OFF);
      begin
        @(posedge clock);
        rec_right.gain_max <= 1'b1;
        @(posedge clock);
        rec_right.gain_max <= 1'b0;
      end
    join
    sat_r = 1'b1;
    rd_chk(apsr_pkg::REC_STATUS_OFF);
    // bit clock edges on primary and secondary pins
    level <= 7'h00;
    wr(8'h20, 8'h00);
    frame(1'b0);
    wr(8'h1f, 8'h20);
    wr(8'h20, 8'h08);
    frame(1'b1);
    route_chk();
    give_verdict();
  end
endmodule
